// ==== ldc_consts.svh ====
// Register offsets, field positions, reset values and timing figures
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define LDC_OFF_OEM_CFG0      8'h00
`define LDC_OFF_OEM_CFG1      8'h04
`define LDC_OFF_OEM_CFG3      8'h08
`define LDC_OFF_OEM_CFG5      8'h0c
`define LDC_OFF_OEM_CAL0      8'h10
`define LDC_OFF_PWR_SETPOINT  8'h14
`define LDC_OFF_MOD_SETPOINT  8'h18
`define LDC_OFF_BIAS_DIRECT   8'h1c
`define LDC_OFF_MOD_DIRECT    8'h20
`define LDC_OFF_BIAS_READBACK 8'h24
`define LDC_OFF_FAULT_MASK    8'h28
`define LDC_OFF_BLANK_TIME    8'h2c
`define LDC_OFF_RX_GAIN       8'h30
`define LDC_OFF_CONTROL       8'h34

// ************************************************************
// Field positions
// ************************************************************
`define LDC_CFG0_MOD_REF      0
`define LDC_CFG1_FB_RES_LSB   0
`define LDC_CFG1_FB_INV       3
`define LDC_CFG1_CUT_POL      4
`define LDC_CFG1_BIAS_POL     5
`define LDC_CFG3_LOS_OFF      0
`define LDC_CFG3_OE           1
`define LDC_CFG5_CUT_EN       7
`define LDC_CAL0_LOOP_OFF     0
`define LDC_CTL_SW_DIS        0
`define LDC_CTL_TX_FAULT      1
`define LDC_CTL_LOS_PIN       2
`define LDC_CTL_POR_DONE      3
`define LDC_CTL_DATA_READY    4
`define LDC_CTL_FAULT_LSB     8

// ************************************************************
// Reset values
// ************************************************************
`define LDC_RST_OE            1'b0
`define LDC_RST_LOOP_OFF      1'b0
`define LDC_RST_BYTE          8'h00
`define LDC_RST_BLANK         8'h01
`define LDC_RST_FB_RES        3'h0
`define LDC_FB_RES_MAX        3'h6
`define LDC_RST_LOS_OE        1'b1
`define LDC_RST_DIV_BYPASS    1'b1

// ************************************************************
// Timing
// ************************************************************
`define LDC_CLK_KHZ           25000
`define LDC_T_POR_MS          50
`define LDC_T_CONV_MS         100
`define LDC_T_LASER_ON_MS     300
`define LDC_T_BLANK_STEP_US   500

`endif

// ==== ldc_pkg.sv ====
// Types shared by the laser drive and fault control block
package ldc_pkg;

    typedef enum logic [1:0] {ST_POR, ST_WAIT, ST_ACTIVE} phase_e;

    typedef struct packed {
        logic supply;
        logic diode;
        logic bias;
        logic power;
        logic sat;
    } faults_s;

    typedef struct packed {
        logic [7:0] code;
        logic       oe;
    } drive_s;

    typedef struct packed {
        phase_e      phase;
        logic [23:0] tick;
        logic [21:0] blank;
        logic        data_ready;
        logic        mod_ref;
        logic        bias_pol;
        logic        cut_pol;
        logic        fb_inv;
        logic [2:0]  fb_res;
        logic        los_off;
        logic        oe;
        logic        cut_en;
        logic        loop_off;
        logic        sw_dis;
        logic [7:0]  pwr_set;
        logic [7:0]  mod_set;
        logic [7:0]  bias_dir;
        logic [7:0]  mod_dir;
        logic [7:0]  blank_time;
        logic [4:0]  mask;
        logic [4:0]  rx_gain;
        faults_s     latched;
        logic        los;
        logic        tx_off_d;
        logic        laser_on;
        drive_s      bias;
        drive_s      modu;
        logic        cut;
        logic        cut_oe;
        logic        tx_fault;
        logic        loop_run;
        logic        los_oe;
        logic        div_bypass;
        logic        conv_run;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] wdata;
        logic        wstrb0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_s;

endpackage : ldc_pkg

// ==== sat_add.sv ====
// Setpoint plus signed table offset, clamped to the DAC range
`timescale 1ns/1ps
module sat_add
(
    // Operands
    input  wire logic [7:0] i_base,
    input  wire logic [7:0] i_offset,
    // Result
    output logic      [7:0] o_sum
);
    logic signed [9:0] wide;

    always_comb
    begin
        wide = $signed({2'b00, i_base}) + $signed({{2{i_offset[7]}}, i_offset});
        if (wide < 10'sd0)
        begin
            o_sum = 8'h00;
        end
        else if (wide > 10'sd255)
        begin
            o_sum = 8'hff;
        end
        else
        begin
            o_sum = wide[7:0];
        end
    end
endmodule : sat_add

// ==== laser_ctrl.sv ====
// Laser drive sequencing, fault latch, loss-of-signal and register slave
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
`include "ldc_consts.svh"
module laser_ctrl
#(
    parameter int unsigned POR_CYC   = `LDC_T_POR_MS * `LDC_CLK_KHZ,
    parameter int unsigned CONV_CYC  = `LDC_T_CONV_MS * `LDC_CLK_KHZ,
    parameter int unsigned LASER_CYC = `LDC_T_LASER_ON_MS * `LDC_CLK_KHZ,
    parameter int unsigned STEP_CYC  = `LDC_T_BLANK_STEP_US * `LDC_CLK_KHZ
                                       / 1000
)
(
    // Clock, reset, enable
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    // AXI4-Lite slave
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // Analog front end and tables
    input  wire logic [4:0]  I_FAULTS,
    input  wire logic        I_RX_BELOW_ASSERT,
    input  wire logic        I_RX_ABOVE_RELEASE,
    input  wire logic [7:0]  I_PWR_TABLE,
    input  wire logic [7:0]  I_MOD_TABLE,
    // Host pins
    input  wire logic        I_TX_OFF,
    input  wire logic        I_RX_LOS_PIN,
    output logic             O_RX_LOS,
    output logic             O_RX_LOS_OE,
    output logic             O_TX_FAULT,
    // Laser drive
    output logic [7:0]       O_BIAS_CODE,
    output logic             O_BIAS_OE,
    output logic             O_BIAS_POL,
    output logic [7:0]       O_MOD_CODE,
    output logic             O_MOD_OE,
    output logic             O_MOD_REF,
    output logic             O_CUTOFF,
    output logic             O_CUTOFF_OE,
    output logic             O_LOOP_RUN,
    output logic [2:0]       O_FB_RES_SEL,
    output logic             O_FB_INV,
    output logic [4:0]       O_RX_GAIN,
    output logic             O_RX_DIV_BYPASS,
    output logic             O_CONV_RUN
);
    ldc_pkg::state_s  r;
    ldc_pkg::state_s  next_r;
    ldc_pkg::faults_s raw;
    logic [7:0]       bias_sum;
    logic [7:0]       mod_sum;
    logic [7:0]       wa;
    logic [7:0]       wb;
    logic             wr_go;
    logic             laser_ok;
    logic [31:0]      rd;
    logic             rd_ok;

    // ************************************************************
    // Temperature compensated setpoints
    // ************************************************************
    sat_add u_bias_sum (.i_base(r.pwr_set), .i_offset(I_PWR_TABLE),
                        .o_sum(bias_sum));
    sat_add u_mod_sum  (.i_base(r.mod_set), .i_offset(I_MOD_TABLE),
                        .o_sum(mod_sum));

    assign raw = I_FAULTS;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_r = r;
        wa     = r.aw_addr;
        wb     = r.wdata[7:0];
        wr_go  = 1'b0;
        rd     = 32'h0;
        rd_ok  = 1'b1;
        laser_ok = 1'b0;
        // Power-on timeline; the count stops once the laser may start
        if (r.tick < 24'(LASER_CYC))
        begin
            next_r.tick = r.tick + 24'h1;
        end
        case (r.phase)
            ldc_pkg::ST_POR:
            begin
                if (r.tick >= 24'(POR_CYC))
                begin
                    next_r.phase = ldc_pkg::ST_WAIT;
                end
            end
            ldc_pkg::ST_WAIT:
            begin
                if (r.tick >= 24'(LASER_CYC))
                begin
                    next_r.phase = ldc_pkg::ST_ACTIVE;
                end
            end
            ldc_pkg::ST_ACTIVE:
            begin
                next_r.phase = ldc_pkg::ST_ACTIVE;
            end
            default:
            begin
                next_r.phase = ldc_pkg::ST_POR;
            end
        endcase
        if (r.tick >= 24'(POR_CYC + CONV_CYC))
        begin
            next_r.data_ready = 1'b1;
        end

        // Fault latch; a new fault wins over the clearing toggle
        next_r.tx_off_d = I_TX_OFF;
        if (I_TX_OFF != r.tx_off_d)
        begin
            next_r.latched = '0;
        end
        if (r.phase == ldc_pkg::ST_ACTIVE)
        begin
            next_r.latched = next_r.latched
                             | (raw & ~r.mask & {4'hf, r.blank == 22'h0});
        end
        next_r.tx_fault = |next_r.latched;

        // Laser on only after the delay, when enabled and fault free
        laser_ok = (r.phase == ldc_pkg::ST_ACTIVE) && r.oe && !I_TX_OFF
                   && !r.sw_dis && !(|next_r.latched);
        next_r.laser_on = laser_ok;
        // Blanking restarts at every turn-on
        if (laser_ok && !r.laser_on)
        begin
            next_r.blank = 22'(((r.blank_time == 8'h0) ? 8'h1 : r.blank_time)
                               * STEP_CYC);
        end
        else if (r.blank != 22'h0)
        begin
            next_r.blank = r.blank - 22'h1;
        end

        // Drive values; shutdown levels follow the polarity bits
        next_r.loop_run = laser_ok && !r.loop_off;
        if (laser_ok)
        begin
            next_r.bias.code = r.loop_off ? r.bias_dir : bias_sum;
            next_r.modu.code = r.loop_off ? r.mod_dir : mod_sum;
        end
        else
        begin
            next_r.bias.code = {8{r.bias_pol}};
            next_r.modu.code = {8{r.mod_ref}};
        end
        next_r.bias.oe = r.oe;
        next_r.modu.oe = r.oe;
        next_r.cut_oe  = r.oe;
        // A fault alone moves the cutoff only when enabled
        if ((r.phase != ldc_pkg::ST_ACTIVE) || !r.oe || I_TX_OFF || r.sw_dis
            || (r.cut_en && |next_r.latched))
        begin
            next_r.cut = r.cut_pol;
        end
        else
        begin
            next_r.cut = !r.cut_pol;
        end

        // Loss of signal with hysteresis
        if (I_RX_BELOW_ASSERT)
        begin
            next_r.los = 1'b1;
        end
        else if (I_RX_ABOVE_RELEASE)
        begin
            next_r.los = 1'b0;
        end

        // ************************************************************
        // Register slave
        // ************************************************************
        if (r.bvalid && I_BREADY)
        begin
            next_r.bvalid = 1'b0;
        end
        if (r.rvalid && I_RREADY)
        begin
            next_r.rvalid = 1'b0;
        end
        if (r.awready && I_AWVALID)
        begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = I_AWADDR;
            wa             = I_AWADDR;
        end
        if (r.wready && I_WVALID)
        begin
            next_r.w_held = 1'b1;
            next_r.wdata  = I_WDATA;
            next_r.wstrb0 = I_WSTRB[0];
            wb            = I_WDATA[7:0];
        end
        // Writes are refused until the power-on wait has passed
        if (next_r.aw_held && next_r.w_held && !r.bvalid)
        begin
            wr_go          = (r.phase != ldc_pkg::ST_POR) && next_r.wstrb0;
            next_r.aw_held = 1'b0;
            next_r.w_held  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = (r.phase == ldc_pkg::ST_POR) ? 2'h2 : 2'h0;
        end
        if (wr_go)
        begin
            case (wa)
                `LDC_OFF_OEM_CFG0:     next_r.mod_ref = wb[`LDC_CFG0_MOD_REF];
                `LDC_OFF_OEM_CFG1:
                begin
                    next_r.bias_pol = wb[`LDC_CFG1_BIAS_POL];
                    next_r.cut_pol  = wb[`LDC_CFG1_CUT_POL];
                    next_r.fb_inv   = wb[`LDC_CFG1_FB_INV];
                    next_r.fb_res   = (wb[2:0] > `LDC_FB_RES_MAX) ?
                                      `LDC_FB_RES_MAX : wb[2:0];
                end
                `LDC_OFF_OEM_CFG3:
                begin
                    next_r.los_off = wb[`LDC_CFG3_LOS_OFF];
                    next_r.oe      = wb[`LDC_CFG3_OE];
                end
                `LDC_OFF_OEM_CFG5:     next_r.cut_en = wb[`LDC_CFG5_CUT_EN];
                `LDC_OFF_OEM_CAL0:     next_r.loop_off = wb[`LDC_CAL0_LOOP_OFF];
                `LDC_OFF_PWR_SETPOINT: next_r.pwr_set = wb;
                `LDC_OFF_MOD_SETPOINT: next_r.mod_set = wb;
                `LDC_OFF_BIAS_DIRECT:  next_r.bias_dir = wb;
                `LDC_OFF_MOD_DIRECT:   next_r.mod_dir = wb;
                `LDC_OFF_FAULT_MASK:   next_r.mask = wb[4:0];
                `LDC_OFF_BLANK_TIME:   next_r.blank_time = wb;
                `LDC_OFF_RX_GAIN:      next_r.rx_gain = wb[4:0];
                `LDC_OFF_CONTROL:      next_r.sw_dis = wb[`LDC_CTL_SW_DIS];
                default:               next_r.sw_dis = r.sw_dis;
            endcase
        end
        case (I_ARADDR)
            `LDC_OFF_OEM_CFG0:     rd[`LDC_CFG0_MOD_REF] = r.mod_ref;
            `LDC_OFF_OEM_CFG1:     rd[7:0] = {2'h0, r.bias_pol, r.cut_pol,
                                              r.fb_inv, r.fb_res};
            `LDC_OFF_OEM_CFG3:     rd[1:0] = {r.oe, r.los_off};
            `LDC_OFF_OEM_CFG5:     rd[`LDC_CFG5_CUT_EN] = r.cut_en;
            `LDC_OFF_OEM_CAL0:     rd[`LDC_CAL0_LOOP_OFF] = r.loop_off;
            `LDC_OFF_PWR_SETPOINT: rd[7:0] = r.pwr_set;
            `LDC_OFF_MOD_SETPOINT: rd[7:0] = r.mod_set;
            `LDC_OFF_BIAS_DIRECT:  rd[7:0] = r.bias_dir;
            `LDC_OFF_MOD_DIRECT:   rd[7:0] = r.mod_dir;
            `LDC_OFF_BIAS_READBACK: rd[7:0] = r.bias.code;
            `LDC_OFF_FAULT_MASK:   rd[4:0] = r.mask;
            `LDC_OFF_BLANK_TIME:   rd[7:0] = r.blank_time;
            `LDC_OFF_RX_GAIN:      rd[4:0] = r.rx_gain;
            `LDC_OFF_CONTROL:
            begin
                rd[`LDC_CTL_SW_DIS]     = r.sw_dis;
                rd[`LDC_CTL_TX_FAULT]   = r.tx_fault;
                rd[`LDC_CTL_LOS_PIN]    = I_RX_LOS_PIN;
                rd[`LDC_CTL_POR_DONE]   = r.phase != ldc_pkg::ST_POR;
                rd[`LDC_CTL_DATA_READY] = r.data_ready;
                rd[12:8]                = r.latched;
            end
            default:               rd_ok = 1'b0;
        endcase
        if (r.arready && I_ARVALID)
        begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = (r.phase == ldc_pkg::ST_POR) ? 32'h0 : rd;
            next_r.rresp  = (!rd_ok || r.phase == ldc_pkg::ST_POR) ?
                            2'h2 : 2'h0;
        end
        // Decoded pins are registered so every output leaves a flip-flop
        next_r.los_oe     = !next_r.los_off;
        next_r.div_bypass = next_r.rx_gain == 5'h0;
        next_r.conv_run   = next_r.phase != ldc_pkg::ST_POR;
        next_r.awready = !next_r.aw_held && !next_r.bvalid;
        next_r.wready  = !next_r.w_held && !next_r.bvalid;
        next_r.arready = !next_r.rvalid && !(r.arready && I_ARVALID);
    end

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            r          <= '0;
            r.phase    <= ldc_pkg::ST_POR;
            r.oe       <= `LDC_RST_OE;
            r.loop_off <= `LDC_RST_LOOP_OFF;
            r.fb_res   <= `LDC_RST_FB_RES;
            r.blank_time <= `LDC_RST_BLANK;
            r.pwr_set  <= `LDC_RST_BYTE;
            r.los_oe   <= `LDC_RST_LOS_OE;
            r.div_bypass <= `LDC_RST_DIV_BYPASS;
        end
        else if (I_CE)
        begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_AWREADY       = r.awready;
    assign O_WREADY        = r.wready;
    assign O_BVALID        = r.bvalid;
    assign O_BRESP         = r.bresp;
    assign O_ARREADY       = r.arready;
    assign O_RVALID        = r.rvalid;
    assign O_RDATA         = r.rdata;
    assign O_RRESP         = r.rresp;
    assign O_TX_FAULT      = r.tx_fault;
    assign O_RX_LOS        = r.los;
    assign O_RX_LOS_OE     = r.los_oe;
    assign O_BIAS_CODE     = r.bias.code;
    assign O_BIAS_OE       = r.bias.oe;
    assign O_BIAS_POL      = r.bias_pol;
    assign O_MOD_CODE      = r.modu.code;
    assign O_MOD_OE        = r.modu.oe;
    assign O_MOD_REF       = r.mod_ref;
    assign O_CUTOFF        = r.cut;
    assign O_CUTOFF_OE     = r.cut_oe;
    assign O_LOOP_RUN      = r.loop_run;
    assign O_FB_RES_SEL    = r.fb_res;
    assign O_FB_INV        = r.fb_inv;
    assign O_RX_GAIN       = r.rx_gain;
    assign O_RX_DIV_BYPASS = r.div_bypass;
    assign O_CONV_RUN      = r.conv_run;

    // ************************************************************
    // Checks
    // ************************************************************
    oe_float_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && !r.oe |=> !O_BIAS_OE && !O_MOD_OE && !O_LOOP_RUN)
        else $error("drive enabled while output enable clear");
    fault_out_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && r.phase == ldc_pkg::ST_ACTIVE && (raw.supply && !r.mask[4])
        |=> O_TX_FAULT && !r.laser_on)
        else $error("unmasked fault did not shut the laser");
    mask_hold_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && !O_TX_FAULT && (raw & ~r.mask) == 5'h0
        && I_TX_OFF == r.tx_off_d |=> !O_TX_FAULT)
        else $error("masked fault raised the fault output");
    blank_sat_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && r.blank != 22'h0 && raw == 5'h01 && !O_TX_FAULT
        && I_TX_OFF == r.tx_off_d |=> !O_TX_FAULT)
        else $error("saturation counted during blanking");
    los_hyst_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && !I_RX_BELOW_ASSERT && !I_RX_ABOVE_RELEASE
        |=> O_RX_LOS == $past(O_RX_LOS))
        else $error("loss state moved between the levels");
    fault_clear_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_TX_OFF != r.tx_off_d && raw == 5'h0 |=> !O_TX_FAULT)
        else $error("toggle did not clear the fault latch");
    cutoff_off_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_TX_OFF |=> O_CUTOFF == $past(r.cut_pol))
        else $error("cutoff not active with transmit disabled");
    por_wait_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        r.phase == ldc_pkg::ST_POR |-> !O_CONV_RUN && !r.laser_on)
        else $error("activity before the power-on wait");
    bias_path_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && laser_ok && r.loop_off |=> O_BIAS_CODE == $past(r.bias_dir))
        else $error("direct bias value not on the DAC");
endmodule : laser_ctrl

// ==== laser_far_end.sv ====
// Model of the laser driver, comparators and host pins beyond the block
`timescale 1ns/1ps
module laser_far_end
#(
    parameter logic [7:0] PWR_OFS = 8'hfe,
    parameter logic [7:0] MOD_OFS = 8'h20
)
(
    // From the bench
    input  wire logic [4:0] i_fault_set,
    input  wire logic       i_los_ext,
    // From the block
    input  wire logic       i_los,
    input  wire logic       i_los_oe,
    // To the block
    output logic      [4:0] o_faults,
    output logic      [7:0] o_pwr_tab,
    output logic      [7:0] o_mod_tab,
    output logic            o_los_pin
);
    // Comparators report a fault level only while the bench raises it
    assign o_faults  = i_fault_set;
    // Fixed temperature, so the table entries never move
    assign o_pwr_tab = PWR_OFS;
    assign o_mod_tab = MOD_OFS;
    // Released pin is taken over by the external driver
    assign o_los_pin = i_los_oe ? i_los : i_los_ext;
endmodule : laser_far_end

// ==== laser_ctrl_test.sv ====
// Self-checking bench for the laser drive and fault control block
`timescale 1ns/1ps
`define CHK(g,e) begin tests_run++; if ((g)!==(e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module laser_ctrl_test;
logic clk=0, rst=1, awv=0, wv=0, bry=0, arv=0, rry=0, tx_off=0;
logic ce=1, below=0, above=1, lext=1;
logic [7:0] aw=0, ar=0;
logic [31:0] wd=0, d;
logic [3:0] ws=4'hf;
logic [1:0] r, b;
logic [4:0] flt=0;
int fails=0, tests_run=0;
wire awr, wrd, bv, arr, rv, los, los_oe, pin, txf, boe, cut, lrun, conv;
wire moe, coe, bpol, mref, fbi, byp;
wire [2:0] fbs;
wire [4:0] gain;
wire [1:0] rresp, bresp;
wire [31:0] rdat;
wire [7:0] bias, modc, pt, mt;
wire [4:0] fa;
laser_far_end i_laser_far_end (.i_fault_set(flt), .i_los_ext(lext),
  .i_los(los), .i_los_oe(los_oe), .o_faults(fa), .o_pwr_tab(pt),
  .o_mod_tab(mt), .o_los_pin(pin));
laser_ctrl #(.POR_CYC(20), .CONV_CYC(10), .LASER_CYC(60), .STEP_CYC(4))
i_laser_ctrl (.I_MCLK(clk), .I_RST(rst), .I_CE(ce), .I_AWADDR(aw),
  .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws),
  .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(bresp), .O_BVALID(bv),
  .I_BREADY(bry), .I_ARADDR(ar), .I_ARVALID(arv), .O_ARREADY(arr),
  .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rry),
  .I_FAULTS(fa), .I_RX_BELOW_ASSERT(below), .I_RX_ABOVE_RELEASE(above),
  .I_PWR_TABLE(pt), .I_MOD_TABLE(mt), .I_TX_OFF(tx_off),
  .I_RX_LOS_PIN(pin), .O_RX_LOS(los), .O_RX_LOS_OE(los_oe),
  .O_TX_FAULT(txf), .O_BIAS_CODE(bias), .O_BIAS_OE(boe), .O_BIAS_POL(bpol),
  .O_MOD_CODE(modc), .O_MOD_OE(moe), .O_MOD_REF(mref), .O_CUTOFF(cut),
  .O_CUTOFF_OE(coe), .O_LOOP_RUN(lrun), .O_FB_RES_SEL(fbs), .O_FB_INV(fbi),
  .O_RX_GAIN(gain), .O_RX_DIV_BYPASS(byp), .O_CONV_RUN(conv));
task wr(input logic [7:0] a, input logic [31:0] v);
    aw <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
    do begin @(posedge clk); if (awr) awv <= 0; if (wrd) wv <= 0; end
    while (!bv);
    b = bresp; bry <= 0;
    @(posedge clk);
endtask : wr
task rd(input logic [7:0] a);
    ar <= a; arv <= 1; rry <= 1;
    do begin @(posedge clk); if (arr) arv <= 0; end while (!rv);
    d = rdat; r = rresp; rry <= 0;
    @(posedge clk);
endtask : rd
task wrap_up;
    $display("mismatches %0d comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask : wrap_up
task t_por;
    `CHK(boe, 1'b0)
    `CHK(moe, 1'b0)
    `CHK(coe, 1'b0)
    `CHK(byp, 1'b1)
    `CHK(los_oe, 1'b1)
    rd(8'h34);
    `CHK(r, 2'h2)
    `CHK(d, 32'h0)
    repeat (25) @(posedge clk);
    `CHK(conv, 1'b1)
endtask : t_por
task t_drive;
    wr(8'h04, 32'h20); wr(8'h0c, 32'h80); wr(8'h14, 32'h10);
    wr(8'h18, 32'hf0); wr(8'h08, 32'h02);
    `CHK(lrun, 1'b0)
    repeat (40) @(posedge clk);
    `CHK(lrun, 1'b1)
    `CHK(bias, 8'h0e)
    `CHK(modc, 8'hff)
    `CHK(cut, 1'b1)
    `CHK(moe, 1'b1)
    `CHK(coe, 1'b1)
    `CHK(b, 2'h0)
    rd(8'h24);
    `CHK(d, 32'h0e)
    rd(8'h3c);
    `CHK(r, 2'h2)
endtask : t_drive
task t_fault;
    flt <= 5'h10; repeat (3) @(posedge clk);
    `CHK(txf, 1'b1)
    `CHK(bias, 8'hff)
    `CHK(cut, 1'b0)
    flt <= 0; tx_off <= 1; repeat (3) @(posedge clk);
    tx_off <= 0; repeat (3) @(posedge clk);
    `CHK(txf, 1'b0)
    wr(8'h28, 32'h1f); flt <= 5'h10; repeat (3) @(posedge clk);
    `CHK(txf, 1'b0)
    `CHK(bias, 8'h0e)
    flt <= 0;
endtask : t_fault
task t_direct;
    wr(8'h10, 32'h01); wr(8'h1c, 32'h33); wr(8'h20, 32'h44);
    repeat (3) @(posedge clk);
    `CHK(bias, 8'h33)
    `CHK(modc, 8'h44)
    `CHK(lrun, 1'b0)
    rd(8'h24);
    `CHK(d, 32'h33)
endtask : t_direct
task t_config;
    wr(8'h04, 32'h3f); repeat (2) @(posedge clk);
    `CHK(fbs, 3'h6)
    `CHK(fbi, 1'b1)
    `CHK(bpol, 1'b1)
    `CHK(cut, 1'b0)
    wr(8'h34, 32'h01); wr(8'h00, 32'h01); repeat (2) @(posedge clk);
    `CHK(cut, 1'b1)
    `CHK(bias, 8'hff)
    `CHK(modc, 8'hff)
    `CHK(mref, 1'b1)
    wr(8'h00, 32'h00); wr(8'h04, 32'h20); repeat (2) @(posedge clk);
    `CHK(modc, 8'h00)
    `CHK(cut, 1'b0)
    wr(8'h34, 32'h00); wr(8'h30, 32'h13); repeat (2) @(posedge clk);
    `CHK(gain, 5'h13)
    `CHK(byp, 1'b0)
    `CHK(cut, 1'b1)
    ws <= 4'h0; wr(8'h14, 32'h55); ws <= 4'hf;
    rd(8'h14);
    `CHK(d, 32'h10)
endtask : t_config
task t_blank;
    wr(8'h28, 32'h00); wr(8'h2c, 32'h02);
    tx_off <= 1; repeat (2) @(posedge clk);
    tx_off <= 0; @(posedge clk);
    flt <= 5'h01; repeat (4) @(posedge clk);
    `CHK(txf, 1'b0)
    repeat (10) @(posedge clk);
    `CHK(txf, 1'b1)
    `CHK(bias, 8'hff)
    flt <= 5'h00; tx_off <= 1; repeat (2) @(posedge clk);
    wr(8'h28, 32'h08); flt <= 5'h08; tx_off <= 0; repeat (3) @(posedge clk);
    `CHK(txf, 1'b0)
    flt <= 5'h0c; repeat (3) @(posedge clk);
    `CHK(txf, 1'b1)
    flt <= 5'h00; tx_off <= 1; repeat (2) @(posedge clk);
    tx_off <= 0; repeat (3) @(posedge clk);
    `CHK(txf, 1'b0)
endtask : t_blank
task t_los;
    below <= 1; above <= 0; repeat (2) @(posedge clk);
    `CHK(los, 1'b1)
    `CHK(pin, 1'b1)
    below <= 0; repeat (3) @(posedge clk);
    `CHK(los, 1'b1)
    above <= 1; repeat (2) @(posedge clk);
    `CHK(los, 1'b0)
    wr(8'h08, 32'h03); lext <= 0; repeat (2) @(posedge clk);
    `CHK(los_oe, 1'b0)
    rd(8'h34);
    `CHK(d[4:2], 3'h6)
    lext <= 1; rd(8'h34);
    `CHK(d[4:2], 3'h7)
    wr(8'h08, 32'h02);
endtask : t_los
task t_ce;
    ce <= 0; tx_off <= 1; repeat (3) @(posedge clk);
    `CHK(cut, 1'b1)
    `CHK(bias, 8'h33)
    tx_off <= 0; ce <= 1; repeat (2) @(posedge clk);
    `CHK(cut, 1'b1)
    `CHK(txf, 1'b0)
endtask : t_ce
task t_txoff;
    rst <= 1; tx_off <= 1; repeat (3) @(posedge clk);
    rst <= 0; @(posedge clk);
    wr(8'h08, 32'h02);
    `CHK(b, 2'h2)
    `CHK(boe, 1'b0)
    repeat (30) @(posedge clk);
    wr(8'h08, 32'h02); wr(8'h04, 32'h20);
    `CHK(b, 2'h0)
    repeat (45) @(posedge clk);
    `CHK(conv, 1'b1)
    `CHK(lrun, 1'b0)
    `CHK(bias, 8'hff)
    `CHK(modc, 8'h00)
    `CHK(cut, 1'b0)
    tx_off <= 0; repeat (3) @(posedge clk);
    `CHK(lrun, 1'b1)
    `CHK(bias, 8'h00)
    `CHK(modc, 8'h20)
    `CHK(cut, 1'b1)
endtask : t_txoff
initial
begin
    forever #20 clk = ~clk;
end
initial
begin
    #200000; fails++; wrap_up;
end
initial
begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_por; t_drive; t_fault; t_direct;
    t_config; t_blank; t_los; t_ce; t_txoff;
    wrap_up;
end
endmodule : laser_ctrl_test
